/* tmrb_defs.vh */
// Constants for the type B timer count and capture register block
`ifndef TMRB_DEFS_VH
`define TMRB_DEFS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TMRB_OFS_INTFLAGS 4'h6
`define TMRB_OFS_STATUS 4'h7
`define TMRB_OFS_DEBUG_HALT_CONTROL 4'h8
`define TMRB_OFS_LATCH 4'h9
`define TMRB_OFS_CNT_LO 4'hA
`define TMRB_OFS_CNT_HI 4'hB
`define TMRB_OFS_CAPTURE_COMPARE_VALUE_LO 4'hC
`define TMRB_OFS_CAPTURE_COMPARE_VALUE_HI 4'hD

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define TMRB_BIT_RUN 0
`define TMRB_BIT_BYPASS 0
`define TMRB_BIT_FLAG 0
`define TMRB_RST_BYTE 8'h00
`define TMRB_RST_WORD 16'h0000

// ----------------------------------------
// Counting modes
// ----------------------------------------
`define TMRB_MODE_PERIODIC 3'h0
`define TMRB_MODE_TIMEOUT 3'h1
`define TMRB_MODE_INTERRUPT_FLAG_BIT_EVT 3'h2
`define TMRB_MODE_INTERRUPT_FLAG_BIT_FRQ 3'h3
`define TMRB_MODE_INTERRUPT_FLAG_BIT_PW 3'h4
`define TMRB_MODE_INTERRUPT_FLAG_BIT_FRQPW 3'h5
`define TMRB_MODE_SINGLE 3'h6
`define TMRB_MODE_PWM8 3'h7

// ----------------------------------------
// Frequency and pulse width sequence states
// ----------------------------------------
`define TMRB_ST_FIRST 3'h1
`define TMRB_ST_MID 3'h2
`define TMRB_ST_SECOND 3'h4

`endif

/* tmrb_match.v */
// Top and compare match detection for the type B timer
`timescale 1ns/10ps
`include "tmrb_defs.vh"

module tmrb_match (
	// Counter and compare values
	input wire [15:0] count_in,
	input wire [15:0] compare_in,
	// Match results
	output wire top_hit_out,
	output wire pwm_wrap_out,
	output wire pwm_hit_out
);

	// ----------------------------------------
	// Full width top match
	// ----------------------------------------
	// 16-bit top
	assign top_hit_out = (count_in == compare_in);

	// ----------------------------------------
	// Byte matches for 8-bit PWM
	// ----------------------------------------
	// independent byte compare
	assign pwm_wrap_out = (count_in[7:0] == compare_in[7:0]);
	assign pwm_hit_out = (count_in[7:0] == compare_in[15:8]);

endmodule // tmrb_match

/* tmrb_count_regs.v */
// Type B timer count, capture and status registers with byte access
`timescale 1ns/10ps
`include "tmrb_defs.vh"

module tmrb_count_regs (
	// Clock and reset
	input wire ref_clk_in,
	input wire arst_n_in,
	// Register port
	input wire [3:0] bus_addr_in,
	input wire [7:0] bus_wdata_in,
	input wire bus_wr_in,
	input wire bus_rd_in,
	output wire [7:0] bus_rdata_out,
	// Configuration and system state
	input wire [2:0] counting_mode_field_in,
	input wire timer_enable_in,
	input wire event_enable_in,
	input wire event_edge_in,
	input wire cpu_halted_in,
	// Event input, level
	input wire event_in,
	// Timer state
	output wire run_out,
	output wire interrupt_flag_bit_out,
	output wire [15:0] count_value_out,
	output wire [15:0] capture_compare_value_out,
	output wire pwm_out
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	reg [7:0] rdata_reg;
	reg [7:0] latch_reg;
	reg [7:0] latch_next;
	reg halt_bypass_bit_reg;
	reg flag_reg;
	reg flag_next;
	reg run_reg;
	reg run_next;
	reg gate_reg;
	reg gate_next;
	reg [2:0] seq_reg;
	reg [2:0] seq_next;
	reg [15:0] cnt_reg;
	reg [15:0] cnt_next;
	reg [15:0] capture_compare_value_reg;
	reg [15:0] capture_compare_value_next;
	reg ev_prev_reg;
	reg pwm_reg;
	reg [7:0] rd_mux;
	reg flag_set;
	wire frozen;
	wire active;
	wire ev_pos;
	wire ev_neg;
	wire ev_sel;
	wire ev_opp;
	wire top_hit;
	wire pwm_wrap;
	wire pwm_hit;
	wire interrupt_flag_bit_mode;
	wire pwm_mode;
	wire wr_cnt_hi;
	wire wr_capture_compare_value_lo;
	wire wr_capture_compare_value_hi;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function [15:0] inc16;
		input [15:0] v;
		begin
			inc16 = v + 16'h0001;
		end
	endfunction

	function is_capture;
		input [2:0] m;
		begin
			is_capture = (m == `TMRB_MODE_INTERRUPT_FLAG_BIT_EVT) ||
				(m == `TMRB_MODE_INTERRUPT_FLAG_BIT_FRQ) ||
				(m == `TMRB_MODE_INTERRUPT_FLAG_BIT_PW) ||
				(m == `TMRB_MODE_INTERRUPT_FLAG_BIT_FRQPW);
		end
	endfunction

	// ----------------------------------------
	// Freeze and event qualification
	// ----------------------------------------
	// freeze on halt
	assign frozen = cpu_halted_in & ~halt_bypass_bit_reg;
	assign active = timer_enable_in & ~frozen;
	// Events are not acted on while frozen; a level change made then is seen as an edge once the freeze ends
	assign ev_pos = active & event_enable_in & event_in & ~ev_prev_reg;
	assign ev_neg = active & event_enable_in & ~event_in & ev_prev_reg;
	assign ev_sel = event_edge_in ? ev_neg : ev_pos;
	assign ev_opp = event_edge_in ? ev_pos : ev_neg;

	assign interrupt_flag_bit_mode = is_capture(counting_mode_field_in);
	assign pwm_mode = (counting_mode_field_in == `TMRB_MODE_PWM8);
	assign wr_cnt_hi = bus_wr_in & (bus_addr_in == `TMRB_OFS_CNT_HI);
	assign wr_capture_compare_value_lo = bus_wr_in & (bus_addr_in == `TMRB_OFS_CAPTURE_COMPARE_VALUE_LO);
	assign wr_capture_compare_value_hi = bus_wr_in & (bus_addr_in == `TMRB_OFS_CAPTURE_COMPARE_VALUE_HI);

	tmrb_match u_match (
		.count_in(cnt_reg),
		.compare_in(capture_compare_value_reg),
		.top_hit_out(top_hit),
		.pwm_wrap_out(pwm_wrap),
		.pwm_hit_out(pwm_hit)
	);

	// ----------------------------------------
	// Counting engine
	// ----------------------------------------
	always @* begin
		cnt_next = cnt_reg;
		capture_compare_value_next = capture_compare_value_reg;
		gate_next = gate_reg;
		seq_next = seq_reg;
		run_next = 1'b0;
		flag_set = 1'b0;
		if (active) begin
			case (counting_mode_field_in)
			`TMRB_MODE_PERIODIC: begin
				run_next = 1'b1;
				if (top_hit) begin
					cnt_next = `TMRB_RST_WORD;
					flag_set = 1'b1;
				end else begin
					cnt_next = inc16(cnt_reg);
				end
			end
			`TMRB_MODE_TIMEOUT: begin
				if (ev_sel) begin
					gate_next = 1'b1;
					cnt_next = `TMRB_RST_WORD;
				end else if (ev_opp) begin
					gate_next = 1'b0;
				end else if (gate_reg) begin
					if (top_hit) begin
						cnt_next = `TMRB_RST_WORD;
						flag_set = 1'b1;
					end else begin
						cnt_next = inc16(cnt_reg);
					end
				end
				run_next = gate_next;
			end
			`TMRB_MODE_INTERRUPT_FLAG_BIT_EVT: begin
				run_next = 1'b1;
				cnt_next = inc16(cnt_reg);
				if (ev_sel) begin
					capture_compare_value_next = cnt_reg;
					flag_set = 1'b1;
				end
			end
			`TMRB_MODE_INTERRUPT_FLAG_BIT_FRQ: begin
				run_next = 1'b1;
				if (ev_sel) begin
					capture_compare_value_next = cnt_reg;
					cnt_next = `TMRB_RST_WORD;
					flag_set = 1'b1;
				end else begin
					cnt_next = inc16(cnt_reg);
				end
			end
			`TMRB_MODE_INTERRUPT_FLAG_BIT_PW: begin
				run_next = 1'b1;
				if (ev_sel) begin
					cnt_next = `TMRB_RST_WORD;
				end else if (ev_opp) begin
					capture_compare_value_next = cnt_reg;
					flag_set = 1'b1;
					cnt_next = inc16(cnt_reg);
				end else begin
					cnt_next = inc16(cnt_reg);
				end
			end
			`TMRB_MODE_INTERRUPT_FLAG_BIT_FRQPW: begin
				if (gate_reg) begin
					cnt_next = inc16(cnt_reg);
				end
				case (seq_reg)
				`TMRB_ST_FIRST: begin
					if (ev_sel) begin
						cnt_next = `TMRB_RST_WORD;
						gate_next = 1'b1;
						seq_next = `TMRB_ST_MID;
					end
				end
				`TMRB_ST_MID: begin
					if (ev_opp) begin
						capture_compare_value_next = cnt_reg;
						seq_next = `TMRB_ST_SECOND;
					end
				end
				`TMRB_ST_SECOND: begin
					if (ev_sel) begin
						cnt_next = cnt_reg;
						gate_next = 1'b0;
						flag_set = 1'b1;
						seq_next = `TMRB_ST_FIRST;
					end
				end
				default: begin
					seq_next = `TMRB_ST_FIRST;
				end
				endcase
				run_next = gate_next;
			end
			`TMRB_MODE_SINGLE: begin
				// Either edge starts when the edge select is set
				if (ev_pos | (event_edge_in & ev_neg)) begin
					gate_next = 1'b1;
					cnt_next = `TMRB_RST_WORD;
				end else if (gate_reg) begin
					if (top_hit) begin
						gate_next = 1'b0;
						flag_set = 1'b1;
					end else begin
						cnt_next = inc16(cnt_reg);
					end
				end
				run_next = gate_next;
			end
			`TMRB_MODE_PWM8: begin
				run_next = 1'b1;
				if (pwm_wrap) begin
					cnt_next = {cnt_reg[15:8], 8'h00};
				end else begin
					cnt_next = {cnt_reg[15:8], cnt_reg[7:0] + 8'h01};
				end
				flag_set = pwm_hit;
			end
			default: begin
				run_next = 1'b0;
			end
			endcase
		end else begin
			// Stopped or frozen: run drops, gate and sequence are held
			run_next = 1'b0;
		end
		if (wr_cnt_hi) begin
			cnt_next = {bus_wdata_in, latch_reg};
		end
		if (pwm_mode) begin
			if (wr_capture_compare_value_lo) begin
				capture_compare_value_next = {capture_compare_value_next[15:8], bus_wdata_in};
			end
			if (wr_capture_compare_value_hi) begin
				capture_compare_value_next = {bus_wdata_in, capture_compare_value_next[7:0]};
			end
		end else if (wr_capture_compare_value_hi) begin
			capture_compare_value_next = {bus_wdata_in, latch_reg};
		end
	end

	// ----------------------------------------
	// Flag and latch updates
	// ----------------------------------------
	always @* begin
		flag_next = flag_reg;
		if (bus_wr_in && bus_addr_in == `TMRB_OFS_INTFLAGS &&
			bus_wdata_in[`TMRB_BIT_FLAG]) begin
			flag_next = 1'b0;
		end
		if (bus_rd_in && bus_addr_in == `TMRB_OFS_CAPTURE_COMPARE_VALUE_LO && interrupt_flag_bit_mode) begin
			flag_next = 1'b0;
		end
		// A same-cycle event keeps the flag set
		if (flag_set) begin
			flag_next = 1'b1;
		end
	end

	always @* begin
		latch_next = latch_reg;
		if (bus_wr_in && (bus_addr_in == `TMRB_OFS_LATCH ||
			bus_addr_in == `TMRB_OFS_CNT_LO ||
			(bus_addr_in == `TMRB_OFS_CAPTURE_COMPARE_VALUE_LO && !pwm_mode))) begin
			latch_next = bus_wdata_in;
		end
		if (bus_rd_in && bus_addr_in == `TMRB_OFS_CNT_LO) begin
			latch_next = cnt_reg[15:8];
		end
		if (bus_rd_in && bus_addr_in == `TMRB_OFS_CAPTURE_COMPARE_VALUE_LO && !pwm_mode) begin
			latch_next = capture_compare_value_reg[15:8];
		end
	end

	// ----------------------------------------
	// Read decode
	// ----------------------------------------
	always @* begin
		case (bus_addr_in)
		`TMRB_OFS_INTFLAGS: rd_mux = {7'h00, flag_reg};
		`TMRB_OFS_STATUS: rd_mux = {7'h00, run_reg};
		`TMRB_OFS_DEBUG_HALT_CONTROL: rd_mux = {7'h00, halt_bypass_bit_reg};
		`TMRB_OFS_LATCH: rd_mux = latch_reg;
		`TMRB_OFS_CNT_LO: rd_mux = cnt_reg[7:0];
		`TMRB_OFS_CNT_HI: rd_mux = latch_reg;
		`TMRB_OFS_CAPTURE_COMPARE_VALUE_LO: rd_mux = capture_compare_value_reg[7:0];
		`TMRB_OFS_CAPTURE_COMPARE_VALUE_HI: rd_mux = pwm_mode ? capture_compare_value_reg[15:8] : latch_reg;
		default: rd_mux = 8'h00;
		endcase
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	// zero on reset, except the sequence state, which loads TMRB_ST_FIRST
	always @(posedge ref_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rdata_reg <= `TMRB_RST_BYTE;
			latch_reg <= `TMRB_RST_BYTE;
			halt_bypass_bit_reg <= 1'b0;
			flag_reg <= 1'b0;
			run_reg <= 1'b0;
			gate_reg <= 1'b0;
			seq_reg <= `TMRB_ST_FIRST;
			cnt_reg <= `TMRB_RST_WORD;
			capture_compare_value_reg <= `TMRB_RST_WORD;
			ev_prev_reg <= 1'b0;
			pwm_reg <= 1'b0;
		end else begin
			if (bus_rd_in) begin
				rdata_reg <= rd_mux;
			end
			latch_reg <= latch_next;
			if (bus_wr_in && bus_addr_in == `TMRB_OFS_DEBUG_HALT_CONTROL) begin
				halt_bypass_bit_reg <= bus_wdata_in[`TMRB_BIT_BYPASS];
			end
			flag_reg <= flag_next;
			run_reg <= run_next;
			gate_reg <= gate_next;
			seq_reg <= seq_next;
			cnt_reg <= cnt_next;
			capture_compare_value_reg <= capture_compare_value_next;
			// Edge history freezes too, so a level change made during a halt shows up as an edge after it
			if (!frozen) begin
				ev_prev_reg <= event_in;
			end
			pwm_reg <= pwm_mode & active &
				(cnt_next[7:0] < capture_compare_value_next[15:8]);
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign bus_rdata_out = rdata_reg;
	assign run_out = run_reg;
	assign interrupt_flag_bit_out = flag_reg;
	assign count_value_out = cnt_reg;
	assign capture_compare_value_out = capture_compare_value_reg;
	assign pwm_out = pwm_reg;

endmodule // tmrb_count_regs

/* tmrb_count_regs_properties.sv */
// Concurrent checks for the timer count and capture registers
`timescale 1ns/10ps
`include "tmrb_defs.vh"

module tmrb_props (
	// Clock and reset
	input wire ref_clk_in,
	input wire arst_n_in,
	// Register port
	input wire [3:0] bus_addr_in,
	input wire [7:0] bus_wdata_in,
	input wire bus_wr_in,
	input wire bus_rd_in,
	input wire [7:0] bus_rdata_out,
	// Configuration and system state
	input wire [2:0] counting_mode_field_in,
	input wire timer_enable_in,
	input wire event_enable_in,
	input wire event_edge_in,
	input wire cpu_halted_in,
	input wire event_in,
	// Timer state
	input wire run_out,
	input wire interrupt_flag_bit_out,
	input wire [15:0] count_value_out,
	input wire [15:0] capture_compare_value_out,
	input wire pwm_out
);
// ----
// Helper state
// ----
// Bypass bit mirrored here, since it is only visible through the bus
reg byp_reg;
wire go = timer_enable_in && (!cpu_halted_in || byp_reg) && !bus_wr_in;
wire m0 = counting_mode_field_in == `TMRB_MODE_PERIODIC;
wire m7 = counting_mode_field_in == `TMRB_MODE_PWM8;
always @(posedge ref_clk_in or negedge arst_n_in) begin
	if (!arst_n_in) begin
		byp_reg <= 1'b0;
	end else if (bus_wr_in && bus_addr_in == `TMRB_OFS_DEBUG_HALT_CONTROL) begin
		byp_reg <= bus_wdata_in[0];
	end
end
default clocking @(posedge ref_clk_in); endclocking
default disable iff (!arst_n_in);
sequence s_rd_lo;
	bus_rd_in && bus_addr_in == `TMRB_OFS_CNT_LO;
endsequence
sequence s_rd_hi;
	bus_rd_in && bus_addr_in == `TMRB_OFS_CNT_HI;
endsequence
// ----
// Properties
// ----
a_status_read: assert property (
	bus_rd_in && bus_addr_in == `TMRB_OFS_STATUS
	|=> bus_rdata_out == {7'h00, $past(run_out)}) else $error("bad status");
a_run_idle: assert property (
	m0 && !timer_enable_in |=> !run_out) else $error("run while idle");
a_freeze_hold: assert property (
	cpu_halted_in && !byp_reg && !bus_wr_in
	|=> $stable(count_value_out)) else $error("count moved in halt");
a_count_step: assert property (
	m0 && go && count_value_out != capture_compare_value_out
	|=> count_value_out == $past(count_value_out) + 16'h0001)
	else $error("count did not step");
a_cnt_hi_wins: assert property (
	bus_wr_in && bus_addr_in == `TMRB_OFS_CNT_HI
	|=> count_value_out[15:8] == $past(bus_wdata_in))
	else $error("count write lost");
a_capture_compare_value_hi_write: assert property (
	bus_wr_in && bus_addr_in == `TMRB_OFS_CAPTURE_COMPARE_VALUE_HI
	|=> capture_compare_value_out[15:8] == $past(bus_wdata_in))
	else $error("compare write lost");
a_flag_sticky: assert property (
	interrupt_flag_bit_out && !bus_wr_in && !bus_rd_in
	|=> interrupt_flag_bit_out) else $error("flag dropped");
a_top_wrap: assert property (
	m0 && go && count_value_out == capture_compare_value_out
	|=> count_value_out == 16'h0000 && interrupt_flag_bit_out)
	else $error("no wrap at top");
a_pwm_flag: assert property (
	m7 && go && count_value_out[7:0] == capture_compare_value_out[15:8]
	|-> ##[1:2] interrupt_flag_bit_out) else $error("no pwm flag");
a_latch_pair: assert property (
	s_rd_lo ##2 s_rd_hi |=> bus_rdata_out == $past(count_value_out[15:8], 3))
	else $error("latch pair wrong");
endmodule // tmrb_props

bind tmrb_count_regs tmrb_props u_props (.ref_clk_in, .arst_n_in,
	.bus_addr_in, .bus_wdata_in, .bus_wr_in, .bus_rd_in, .bus_rdata_out,
	.counting_mode_field_in, .timer_enable_in, .event_enable_in,
	.event_edge_in, .cpu_halted_in, .event_in, .run_out,
	.interrupt_flag_bit_out, .count_value_out, .capture_compare_value_out,
	.pwm_out);

/* tmrb_tb.sv */
// Self-checking bench for the timer count and capture registers
`timescale 1ns/10ps
`include "tmrb_defs.vh"

module tb;
// ----
// Design hookup
// ----
reg ref_clk_in = 1'b0;
reg arst_n_in = 1'b0;
reg [3:0] bus_addr_in = 4'h0;
reg [7:0] bus_wdata_in = 8'h00;
reg bus_wr_in = 1'b0;
reg bus_rd_in = 1'b0;
reg [2:0] counting_mode_field_in = 3'h0;
reg timer_enable_in = 1'b0;
reg event_enable_in = 1'b0;
reg event_edge_in = 1'b0;
reg cpu_halted_in = 1'b0;
reg event_in = 1'b0;
wire [7:0] bus_rdata_out;
wire run_out;
wire interrupt_flag_bit_out;
wire [15:0] count_value_out;
wire [15:0] capture_compare_value_out;
wire pwm_out;
wire flg = interrupt_flag_bit_out;
wire [15:0] cnt = count_value_out;
wire [15:0] cc = capture_compare_value_out;
integer fails = 0;
integer checks_done = 0;
integer i;
integer m;
reg [7:0] got;
reg [15:0] c0;
always #20 ref_clk_in = ~ref_clk_in;
tmrb_count_regs u_dut (.ref_clk_in, .arst_n_in, .bus_addr_in, .bus_wdata_in,
	.bus_wr_in, .bus_rd_in, .bus_rdata_out, .counting_mode_field_in,
	.timer_enable_in, .event_enable_in, .event_edge_in, .cpu_halted_in,
	.event_in, .run_out, .interrupt_flag_bit_out, .count_value_out,
	.capture_compare_value_out, .pwm_out);
// ----
// Shared tasks
// ----
task chk(input string nm, input [15:0] e, input [15:0] g);
	begin
		checks_done = checks_done + 1;
		if (g !== e) begin
			fails = fails + 1;
			$display("[ERR] %0s expected %h seen %h", nm, e, g);
		end
	end
endtask
task close_out;
	begin
		if (fails == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	end
endtask
// Strobe held one cycle, then an idle cycle before the next access
task wrb(input [3:0] a, input [7:0] d);
	begin
		@(negedge ref_clk_in);
		bus_addr_in = a;
		bus_wdata_in = d;
		bus_wr_in = 1'b1;
		@(negedge ref_clk_in);
		bus_wr_in = 1'b0;
	end
endtask
task rdb(input [3:0] a);
	begin
		@(negedge ref_clk_in);
		bus_addr_in = a;
		bus_rd_in = 1'b1;
		@(negedge ref_clk_in);
		bus_rd_in = 1'b0;
		got = bus_rdata_out;
	end
endtask
task tick(input integer n);
	repeat (n) @(negedge ref_clk_in);
endtask
task wflag;
	begin
		i = 0;
		while (flg !== 1'b1 && i < 60) begin
			@(negedge ref_clk_in);
			i = i + 1;
		end
	end
endtask
// ----
// Scenarios
// ----
task t_reset;
	for (m = 0; m < 16; m = m + 1) begin
		rdb(m[3:0]);
		chk("rst", 16'h0000, {8'h00, got});
	end
endtask
task t_regs;
	begin
		wrb(4'h9, 8'h5A);
		rdb(4'h9);
		chk("latch", 16'h005A, {8'h00, got});
		wrb(4'h7, 8'hFF);
		rdb(4'h7);
		chk("status", 16'h0000, {8'h00, got});
	end
endtask
task t_cnt16;
	begin
		wrb(4'hA, 8'h34);
		wrb(4'hB, 8'h12);
		chk("cnt", 16'h1234, cnt);
		wrb(4'hC, 8'hCD);
		wrb(4'hD, 8'hAB);
		chk("capture_compare_value", 16'hABCD, cc);
		rdb(4'hA);
		chk("cnt_lo", 16'h0034, {8'h00, got});
		rdb(4'hB);
		chk("cnt_hi", 16'h0012, {8'h00, got});
		rdb(4'hC);
		rdb(4'h9);
		chk("shared", 16'h00AB, {8'h00, got});
	end
endtask
task t_run;
	begin
		wrb(4'hC, 8'hFF);
		wrb(4'hD, 8'hFF);
		timer_enable_in = 1'b1;
		tick(3);
		wrb(4'hA, 8'h00);
		wrb(4'hB, 8'h80);
		chk("cnt_wr", 16'h8000, cnt);
		rdb(4'h7);
		chk("run", 16'h0001, {8'h00, got});
		chk("run_pin", 16'h0001, {15'h0000, run_out});
		timer_enable_in = 1'b0;
		tick(2);
		rdb(4'h7);
		chk("stop", 16'h0000, {8'h00, got});
		chk("stop_pin", 16'h0000, {15'h0000, run_out});
	end
endtask
// Top value must end the count in each top-driven mode: wrap to 0, or hold at top in single mode
task t_top(input [2:0] md, input [15:0] ec);
	begin
		event_in = 1'b0;
		wrb(4'h6, 8'h01);
		wrb(4'hA, 8'h00);
		wrb(4'hB, 8'h00);
		counting_mode_field_in = md;
		event_enable_in = 1'b1;
		timer_enable_in = 1'b1;
		@(negedge ref_clk_in);
		event_in = 1'b1;
		wflag;
		chk("top_flag", 16'h0001, {15'h0000, flg});
		chk("top_cnt", ec, cnt);
		timer_enable_in = 1'b0;
		wrb(4'h6, 8'h01);
		chk("w1c", 16'h0000, {15'h0000, flg});
	end
endtask
task t_halt;
	begin
		counting_mode_field_in = `TMRB_MODE_PERIODIC;
		wrb(4'hC, 8'hFF);
		wrb(4'hD, 8'hFF);
		cpu_halted_in = 1'b1;
		timer_enable_in = 1'b1;
		c0 = cnt;
		tick(5);
		chk("frozen", c0, cnt);
		wrb(4'h8, 8'h01);
		c0 = cnt;
		tick(5);
		chk("bypass", c0 + 16'h0005, cnt);
		timer_enable_in = 1'b0;
		cpu_halted_in = 1'b0;
		wrb(4'h8, 8'h00);
	end
endtask
task t_interrupt_flag_bit(input [2:0] md);
	begin
		counting_mode_field_in = md;
		timer_enable_in = 1'b1;
		event_in = 1'b0;
		tick(3);
		wrb(4'h6, 8'h01);
		c0 = cnt;
		event_in = 1'b1;
		tick(3);
		if (md == `TMRB_MODE_INTERRUPT_FLAG_BIT_EVT)
			chk("interrupt_flag_bit", c0, cc);
		event_in = 1'b0;
		tick(3);
		event_in = 1'b1;
		tick(3);
		chk("c_flag", 16'h0001, {15'h0000, flg});
		rdb(4'hC);
		chk("rd_clr", 16'h0000, {15'h0000, flg});
		timer_enable_in = 1'b0;
	end
endtask
task t_pwm;
	begin
		counting_mode_field_in = `TMRB_MODE_PWM8;
		wrb(4'hA, 8'h00);
		wrb(4'hB, 8'h00);
		wrb(4'h9, 8'h77);
		wrb(4'hC, 8'h04);
		wrb(4'hD, 8'h02);
		chk("pwm_cc", 16'h0204, cc);
		rdb(4'h9);
		chk("pwm_lat", 16'h0077, {8'h00, got});
		wrb(4'h6, 8'h01);
		timer_enable_in = 1'b1;
		wflag;
		chk("pwm_flag", 16'h0001, {15'h0000, flg});
		// Count now sits at 3, above the high byte of 2
		chk("pwm_low", 16'h0000, {15'h0000, pwm_out});
		tick(2);
		// Low byte wrapped past 4 back to 0, below the high byte
		chk("pwm_high", 16'h0001, {15'h0000, pwm_out});
		timer_enable_in = 1'b0;
	end
endtask
// ----
// Main sequence and watchdog
// ----
initial begin
	repeat (16) @(negedge ref_clk_in);
	arst_n_in = 1'b1;
	t_reset;
	t_regs;
	t_cnt16;
	t_run;
	wrb(4'hC, 8'h03);
	wrb(4'hD, 8'h00);
	t_top(`TMRB_MODE_PERIODIC, 16'h0000);
	t_top(`TMRB_MODE_TIMEOUT, 16'h0000);
	t_top(`TMRB_MODE_SINGLE, 16'h0003);
	t_halt;
	for (m = 2; m < 6; m = m + 1)
		t_interrupt_flag_bit(m[2:0]);
	t_pwm;
	close_out;
end
// Whole run is well under a thousand cycles; this margin is generous
initial begin
	#400000;
	fails = fails + 1;
	close_out;
end
endmodule // tb
